// [hw/scu_socket_command_unit.sv]
// Socket command unit: command register, background connection sequencing, status and flags
`timescale 1ns/1ps
`include "scu_map.svh"
module scu_socket_command_unit #(
   parameter int         RES_TIMEOUT_CYCLES = `SCU_RES_TIMEOUT_US * (`SCU_CLK_HZ / 1000000),
   parameter int         TCP_TIMEOUT_CYCLES = `SCU_TCP_TIMEOUT_US * (`SCU_CLK_HZ / 1000000),
   parameter int         TIMER_W            = 16,
   parameter logic [7:0] LISTEN_CODE        = `SCU_ST_LISTEN_DFLT,
   parameter logic [7:0] CONNECTED_CODE     = `SCU_ST_CONN_DFLT
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        resolution_done,
   input  wire logic        synack_received,
   input  wire logic        rst_received,
   input  wire logic        client_connected,
   input  wire logic        client_failed,
   output logic             resolution_request,
   output logic             syn_request,
   output logic             listen_active,
   output logic [31:0]      dest_ip_reg,
   output logic [15:0]      dest_port_reg
);
   import scu_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Command byte to command kind
   function automatic scu_pkg::scu_cmd_type scu_decode_cmd(input logic [7:0] code);
      case (code)
         `SCU_CMD_IDLE:    scu_decode_cmd = SCU_CMD_NONE;
         `SCU_CMD_OPEN:    scu_decode_cmd = SCU_CMD_OPEN;
         `SCU_CMD_LISTEN:  scu_decode_cmd = SCU_CMD_LISTEN;
         `SCU_CMD_CONNECT: scu_decode_cmd = SCU_CMD_CONNECT;
         default:          scu_decode_cmd = SCU_CMD_OTHER;
      endcase
   endfunction

   // Status that open gives for a mode; closed code means no valid protocol
   function automatic logic [7:0] scu_open_status(input logic [7:0] mode);
      case (mode[`SCU_PROTO_MSB:0])
         `SCU_PROTO_TCP: scu_open_status = `SCU_ST_TCP_INIT;
         `SCU_PROTO_UDP: scu_open_status = `SCU_ST_DGRAM;
         `SCU_PROTO_RAW: scu_open_status = `SCU_ST_RAW;
         default:        scu_open_status = `SCU_ST_CLOSED;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave and timer

   scu_reg_if bus_if ();

   scu_ahb_slave u_slave (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .regs      (bus_if.slave)
   );

   logic               timer_load;
   logic [TIMER_W-1:0] timer_limit;
   logic               timer_run;
   logic               timer_expired;

   scu_timer #(
      .TIMER_W (TIMER_W)
   ) u_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .load    (timer_load),
      .limit   (timer_limit),
      .run     (timer_run),
      .expired (timer_expired)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // State

   logic [7:0]    socket_mode_reg;
   logic [7:0]    socket_command_reg;
   logic [7:0]    socket_interrupt_flags;
   logic [7:0]    socket_status_code;
   scu_phase_type phase;

   logic [7:0]    next_mode;
   logic [7:0]    next_command;
   logic [7:0]    next_flags;
   logic [7:0]    next_status;
   logic [31:0]   next_dest_ip;
   logic [15:0]   next_dest_port;
   scu_phase_type next_phase;
   logic          next_resolution_request;
   logic          next_syn_request;
   logic          next_listen_active;

   scu_cmd_type   cmd_kind;
   logic          accept;
   logic          is_tcp;
   logic          open_ok;
   logic          listen_ok;
   logic          connect_ok;
   logic          set_con;
   logic          set_timeout;
   logic [7:0]    flag_clear;

   ////////////////////////////////////////////////////////////////////////////////
   // Command acceptance

   // Decode the pending command and check it against mode and status
   always_comb begin
      cmd_kind   = scu_decode_cmd(socket_command_reg);
      accept     = socket_command_reg != `SCU_CMD_IDLE;
      is_tcp     = socket_mode_reg[`SCU_PROTO_MSB:0] == `SCU_PROTO_TCP;
      open_ok    = accept && cmd_kind == SCU_CMD_OPEN &&
                   scu_open_status(socket_mode_reg) != `SCU_ST_CLOSED;
      listen_ok  = accept && cmd_kind == SCU_CMD_LISTEN && is_tcp &&
                   socket_status_code == `SCU_ST_TCP_INIT && phase == SCU_PH_IDLE;
      connect_ok = accept && cmd_kind == SCU_CMD_CONNECT && is_tcp &&
                   socket_status_code == `SCU_ST_TCP_INIT && phase == SCU_PH_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register file

   // Host writes, command self clear, write-one-to-clear flags, read mux
   always_comb begin
      next_mode      = socket_mode_reg;
      next_dest_ip   = dest_ip_reg;
      next_dest_port = dest_port_reg;
      flag_clear     = 8'h00;
      next_command   = accept ? `SCU_CMD_IDLE : socket_command_reg;
      if (bus_if.wr_en) begin
         case (bus_if.wr_index)
            `SCU_IDX_MODE:      next_mode      = bus_if.wdata[7:0];
            `SCU_IDX_COMMAND:   next_command   = bus_if.wdata[7:0];
            `SCU_IDX_FLAGS:     flag_clear     = bus_if.wdata[7:0];
            `SCU_IDX_DEST_IP:   next_dest_ip   = bus_if.wdata;
            `SCU_IDX_DEST_PORT: next_dest_port = bus_if.wdata[15:0];
            default:            next_mode      = socket_mode_reg;
         endcase
      end
      // completion and timeout flags; set wins over clear
      next_flags = ((socket_interrupt_flags & ~flag_clear) |
                    (8'(set_con) << `SCU_FLAG_CON) |
                    (8'(set_timeout) << `SCU_FLAG_TIMEOUT)) & `SCU_FLAG_MASK;
      case (bus_if.rd_index)
         `SCU_IDX_MODE:      bus_if.rdata = {24'h000000, socket_mode_reg};
         `SCU_IDX_COMMAND:   bus_if.rdata = {24'h000000, socket_command_reg};
         `SCU_IDX_FLAGS:     bus_if.rdata = {24'h000000, socket_interrupt_flags};
         `SCU_IDX_STATUS:    bus_if.rdata = {24'h000000, socket_status_code};
         `SCU_IDX_DEST_IP:   bus_if.rdata = dest_ip_reg;
         `SCU_IDX_DEST_PORT: bus_if.rdata = {16'h0000, dest_port_reg};
         default:            bus_if.rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         socket_mode_reg        <= `SCU_RST_BYTE;
         socket_command_reg     <= `SCU_RST_BYTE;
         socket_interrupt_flags <= `SCU_RST_BYTE;
         dest_ip_reg            <= 32'h00000000;
         dest_port_reg          <= 16'h0000;
      end else begin
         socket_mode_reg        <= next_mode;
         socket_command_reg     <= next_command;
         socket_interrupt_flags <= next_flags;
         dest_ip_reg            <= next_dest_ip;
         dest_port_reg          <= next_dest_port;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Background sequencing

   // Phase, status and requests toward the network engine
   always_comb begin
      next_phase              = phase;
      next_status             = socket_status_code;
      next_resolution_request = resolution_request;
      next_syn_request        = 1'b0;
      next_listen_active      = listen_active;
      set_con                 = 1'b0;
      set_timeout             = 1'b0;
      timer_load              = 1'b0;
      timer_limit             = TIMER_W'(RES_TIMEOUT_CYCLES);
      timer_run               = phase == SCU_PH_RESOLVE || phase == SCU_PH_SYN_WAIT;
      if (open_ok) begin
         next_phase              = SCU_PH_IDLE;
         next_status             = scu_open_status(socket_mode_reg);
         next_resolution_request = 1'b0;
         next_listen_active      = 1'b0;
      end else if (listen_ok) begin
         next_phase         = SCU_PH_LISTEN;
         next_status        = LISTEN_CODE;
         next_listen_active = 1'b1;
      end else if (connect_ok) begin
         next_phase              = SCU_PH_RESOLVE;
         next_resolution_request = 1'b1;
         timer_load              = 1'b1;
      end else begin
         case (phase)
            SCU_PH_RESOLVE: begin
               if (resolution_done) begin
                  next_phase              = SCU_PH_SYN_WAIT;
                  next_resolution_request = 1'b0;
                  next_syn_request        = 1'b1;
                  timer_load              = 1'b1;
                  timer_limit             = TIMER_W'(TCP_TIMEOUT_CYCLES);
               end else if (timer_expired) begin
                  next_phase              = SCU_PH_IDLE;
                  next_status             = `SCU_ST_CLOSED;
                  next_resolution_request = 1'b0;
                  set_timeout             = 1'b1;
               end
            end
            SCU_PH_SYN_WAIT: begin
               if (synack_received) begin
                  next_phase  = SCU_PH_IDLE;
                  next_status = CONNECTED_CODE;
                  set_con     = 1'b1;
               end else if (rst_received) begin
                  next_phase  = SCU_PH_IDLE;
                  next_status = `SCU_ST_CLOSED;
               end else if (timer_expired) begin
                  next_phase  = SCU_PH_IDLE;
                  next_status = `SCU_ST_CLOSED;
                  set_timeout = 1'b1;
               end
            end
            SCU_PH_LISTEN: begin
               if (client_connected) begin
                  next_phase         = SCU_PH_IDLE;
                  next_status        = CONNECTED_CODE;
                  next_listen_active = 1'b0;
                  set_con            = 1'b1;
               end else if (client_failed) begin
                  next_phase         = SCU_PH_IDLE;
                  next_status        = `SCU_ST_CLOSED;
                  next_listen_active = 1'b0;
                  set_timeout        = 1'b1;
               end
            end
            default: begin
               next_phase = SCU_PH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase              <= SCU_PH_IDLE;
         socket_status_code <= `SCU_ST_CLOSED;
         resolution_request <= 1'b0;
         syn_request        <= 1'b0;
         listen_active      <= 1'b0;
      end else begin
         phase              <= next_phase;
         socket_status_code <= next_status;
         resolution_request <= next_resolution_request;
         syn_request        <= next_syn_request;
         listen_active      <= next_listen_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Helper count of cycles spent waiting for address resolution
   logic [TIMER_W-1:0] res_wait;
   logic [TIMER_W-1:0] next_res_wait;

   // Count up while resolving, restart from zero elsewhere
   always_comb begin
      next_res_wait = '0;
      if (phase == SCU_PH_RESOLVE) begin
         next_res_wait = res_wait + TIMER_W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         res_wait <= '0;
      end else begin
         res_wait <= next_res_wait;
      end
   end

   AST_CMD_CLEAR: assert property (
      accept && !(bus_if.wr_en && bus_if.wr_index == `SCU_IDX_COMMAND)
      |=> socket_command_reg == `SCU_CMD_IDLE)
      else $error("command register not cleared after acceptance");

   AST_BACKGROUND: assert property (
      connect_ok |=> socket_command_reg == `SCU_CMD_IDLE && phase == SCU_PH_RESOLVE
                     && resolution_request && socket_status_code == `SCU_ST_TCP_INIT)
      else $error("connect did not continue after command cleared");

   AST_OPEN_STATUS: assert property (
      open_ok |=> socket_status_code == scu_open_status($past(socket_mode_reg)))
      else $error("open gave wrong status for mode");

   AST_LISTEN: assert property (
      listen_ok |=> socket_status_code == LISTEN_CODE && listen_active)
      else $error("listen did not reach listening status");

   AST_INVALID_KEEPS: assert property (
      accept && !open_ok && !listen_ok && !connect_ok && phase == SCU_PH_IDLE
      |=> $stable(socket_status_code))
      else $error("invalid command changed the status");

   AST_LISTEN_OK: assert property (
      phase == SCU_PH_LISTEN && client_connected && !open_ok
      |=> socket_status_code == CONNECTED_CODE && socket_interrupt_flags[`SCU_FLAG_CON])
      else $error("listener success not reported");

   AST_LISTEN_FAIL: assert property (
      phase == SCU_PH_LISTEN && !client_connected && client_failed && !open_ok
      |=> socket_status_code == `SCU_ST_CLOSED
          && socket_interrupt_flags[`SCU_FLAG_TIMEOUT])
      else $error("listener failure not reported");

   AST_SYN_SENT: assert property (
      phase == SCU_PH_RESOLVE && resolution_done && !open_ok
      |=> syn_request && !resolution_request ##1 !syn_request)
      else $error("SYN request missing or longer than one cycle");

   AST_CONNECTED: assert property (
      phase == SCU_PH_SYN_WAIT && synack_received && !open_ok
      |=> socket_status_code == CONNECTED_CODE && socket_interrupt_flags[`SCU_FLAG_CON])
      else $error("connect success not reported");

   AST_RES_TIMEOUT: assert property (
      phase == SCU_PH_RESOLVE && res_wait == TIMER_W'(RES_TIMEOUT_CYCLES - 1)
      && !resolution_done && !open_ok
      |=> socket_status_code == `SCU_ST_CLOSED
          && socket_interrupt_flags[`SCU_FLAG_TIMEOUT])
      else $error("resolution timeout not reported in time");

   AST_RES_NOT_EARLY: assert property (
      phase == SCU_PH_RESOLVE && res_wait < TIMER_W'(RES_TIMEOUT_CYCLES - 1) && !open_ok
      |=> socket_status_code == `SCU_ST_TCP_INIT)
      else $error("resolution wait ended too early");

   AST_TCP_TIMEOUT: assert property (
      phase == SCU_PH_SYN_WAIT && timer_expired && !synack_received && !rst_received
      && !open_ok |=> socket_status_code == `SCU_ST_CLOSED
                      && socket_interrupt_flags[`SCU_FLAG_TIMEOUT])
      else $error("transport timeout not reported");

   AST_RST_CLOSES: assert property (
      phase == SCU_PH_SYN_WAIT && rst_received && !synack_received && !open_ok
      |=> socket_status_code == `SCU_ST_CLOSED && phase == SCU_PH_IDLE)
      else $error("reset segment did not close the socket");

   AST_FLAG_SET_WINS: assert property (
      set_timeout |=> socket_interrupt_flags[`SCU_FLAG_TIMEOUT]
                      && socket_status_code == `SCU_ST_CLOSED)
      else $error("failure flag lost or socket not closed");
endmodule

// [hw/scu_map.svh]
// Register map, field positions, codes and timing constants of the socket command unit
`ifndef SCU_MAP_SVH
`define SCU_MAP_SVH

// Register indexes; byte address is four times the index
`define SCU_IDX_W           6
`define SCU_IDX_MODE        6'h00
`define SCU_IDX_COMMAND     6'h01
`define SCU_IDX_FLAGS       6'h02
`define SCU_IDX_STATUS      6'h03
`define SCU_IDX_DEST_IP     6'h04
`define SCU_IDX_DEST_PORT   6'h05

// Reset value of every register
`define SCU_RST_BYTE        8'h00

// Command codes
`define SCU_CMD_IDLE        8'h00
`define SCU_CMD_OPEN        8'h01
`define SCU_CMD_LISTEN      8'h02
`define SCU_CMD_CONNECT     8'h04

// Protocol field of the mode register
`define SCU_PROTO_MSB       3
`define SCU_PROTO_TCP       4'h1
`define SCU_PROTO_UDP       4'h2
`define SCU_PROTO_RAW       4'h4

// Status codes
`define SCU_ST_CLOSED       8'h00
`define SCU_ST_TCP_INIT     8'h13
`define SCU_ST_DGRAM        8'h22
`define SCU_ST_RAW          8'h02
`define SCU_ST_LISTEN_DFLT  8'h30
`define SCU_ST_CONN_DFLT    8'h31

// Interrupt flag bits; bits 7..5 are reserved and read zero
`define SCU_FLAG_CON        0
`define SCU_FLAG_TIMEOUT    3
`define SCU_FLAG_MASK       8'h1f

// AHB-Lite encodings
`define SCU_HSIZE_WORD      3'b010

// Timing
`define SCU_CLK_HZ          25000000
`define SCU_RES_TIMEOUT_US  200
`define SCU_TCP_TIMEOUT_US  1000

`endif

// [hw/scu_pkg.sv]
// Types shared by the socket command unit modules
package scu_pkg;

   // Background phase of the command in progress
   typedef enum logic [1:0] {
      SCU_PH_IDLE,
      SCU_PH_RESOLVE,
      SCU_PH_SYN_WAIT,
      SCU_PH_LISTEN
   } scu_phase_type;

   // Decoded command kinds
   typedef enum logic [2:0] {
      SCU_CMD_NONE,
      SCU_CMD_OPEN,
      SCU_CMD_LISTEN,
      SCU_CMD_CONNECT,
      SCU_CMD_OTHER
   } scu_cmd_type;

endpackage

// [hw/scu_reg_if.sv]
// Register access carrier between the bus slave and the command unit core
`timescale 1ns/1ps
`include "scu_map.svh"
interface scu_reg_if;
   logic                   wr_en;
   logic [`SCU_IDX_W-1:0]  wr_index;
   logic [31:0]            wdata;
   logic [`SCU_IDX_W-1:0]  rd_index;
   logic [31:0]            rdata;

   modport slave (output wr_en, output wr_index, output wdata, output rd_index,
                  input rdata);
   modport core  (input wr_en, input wr_index, input wdata, input rd_index,
                  output rdata);
endinterface

// [hw/scu_timer.sv]
// Down counter that flags the end of a loaded timeout while it runs
`timescale 1ns/1ps
module scu_timer #(
   parameter int TIMER_W = 16
) (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               load,
   input  wire logic [TIMER_W-1:0] limit,
   input  wire logic               run,
   output logic                    expired
);
   logic [TIMER_W-1:0] count;
   logic [TIMER_W-1:0] next_count;

   // Load wins, else count down while running
   always_comb begin
      next_count = count;
      if (load) begin
         next_count = limit;
      end else if (run && count != '0) begin
         next_count = count - TIMER_W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // One-cycle pulse on the last count
   assign expired = run && !load && count == TIMER_W'(1);
endmodule

// [hw/scu_ahb_slave.sv]
// AHB-Lite slave front end: writes with no wait, reads with one wait state
`timescale 1ns/1ps
`include "scu_map.svh"
module scu_ahb_slave (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   scu_reg_if.slave         regs
);
   logic                  take;
   logic                  pend_wr;
   logic                  pend_rd;
   logic [`SCU_IDX_W-1:0] addr_idx;
   logic                  next_pend_wr;
   logic                  next_pend_rd;
   logic [`SCU_IDX_W-1:0] next_addr_idx;
   logic [31:0]           next_hrdata;
   logic                  next_hreadyout;

   // Address phase capture; read data is fetched in the wait cycle
   always_comb begin
      take           = hsel && htrans[1] && hready;
      next_pend_wr   = take && hwrite && hsize == `SCU_HSIZE_WORD;
      next_pend_rd   = take && !hwrite;
      next_addr_idx  = take ? haddr[`SCU_IDX_W+1:2] : addr_idx;
      next_hreadyout = !next_pend_rd;
      next_hrdata    = pend_rd ? regs.rdata : hrdata;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_wr   <= 1'b0;
         pend_rd   <= 1'b0;
         addr_idx  <= '0;
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         pend_wr   <= next_pend_wr;
         pend_rd   <= next_pend_rd;
         addr_idx  <= next_addr_idx;
         hrdata    <= next_hrdata;
         hreadyout <= next_hreadyout;
         hresp     <= 1'b0;
      end
   end

   // Write data stands in the data phase
   assign regs.wr_en    = pend_wr;
   assign regs.wr_index = addr_idx;
   assign regs.wdata    = hwdata;
   assign regs.rd_index = addr_idx;
endmodule

// [sim/scu_peer_model.sv]
// Far-side network engine model answering the unit's requests
`timescale 1ns/1ps
module scu_peer_model (
   input  wire logic       hclk,
   input  wire logic [2:0] peer_mode,
   input  wire logic       resolution_request,
   input  wire logic       syn_request,
   input  wire logic       listen_active,
   output logic            resolution_done = 1'b0,
   output logic            synack_received = 1'b0,
   output logic            rst_received = 1'b0,
   output logic            client_connected = 1'b0,
   output logic            client_failed = 1'b0
);
   logic [3:0] wait_cnt = 4'h0;
   logic       syn_seen = 1'b0;
   logic       fire;
   // Answers come three cycles into a request, so the unit must really wait
   assign fire = (wait_cnt == 4'h3);
   // Modes: 0 good, 1 silent, 2 no handshake reply, 3 reset segment, 4 client refused
   always @(posedge hclk) begin
      wait_cnt <= (resolution_request | syn_seen | listen_active) ? wait_cnt + 4'h1 : 4'h0;
      syn_seen <= syn_request | (syn_seen & !fire);
      resolution_done  <= resolution_request & fire & (peer_mode != 3'd1);
      synack_received  <= syn_seen & fire & (peer_mode == 3'd0);
      rst_received     <= syn_seen & fire & (peer_mode == 3'd3);
      client_connected <= listen_active & fire & (peer_mode == 3'd0);
      client_failed    <= listen_active & fire & (peer_mode == 3'd4);
   end
endmodule

// [sim/scu_socket_command_unit_tb.sv]
// Self-checking bench of the socket command unit over its register bus
`timescale 1ns/1ps
module scu_socket_command_unit_tb;
   logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  peer_mode = 3'd1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, dest_ip_reg, rd;
   logic [15:0] dest_port_reg;
   logic        resolution_done, synack_received, rst_received, client_connected;
   logic        client_failed, resolution_request, syn_request, listen_active;
   logic [31:0] pr_tab [4] = '{32'h0, 32'h1, 32'h2, 32'h4};
   logic [31:0] st_tab [4] = '{32'h0, 32'h13, 32'h22, 32'h02};
   int          n_errors = 0;
   int          cmp_count = 0;

   scu_socket_command_unit #(.RES_TIMEOUT_CYCLES(20), .TCP_TIMEOUT_CYCLES(40)) uut (
      .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .resolution_done, .synack_received,
      .rst_received, .client_connected, .client_failed, .resolution_request, .syn_request,
      .listen_active, .dest_ip_reg, .dest_port_reg);
   scu_peer_model peer (.hclk, .peer_mode, .resolution_request, .syn_request, .listen_active,
      .resolution_done, .synack_received, .rst_received, .client_connected, .client_failed);

   // Clock of 40 ns
   initial forever #20 hclk = ~hclk;

   // Compare one value and count it
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One single bus transfer; read data lands in rd
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(what, exp, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   // Poll status until it reads the expected code, then check and clear the flags
   task automatic expect_sf(input logic [31:0] st, input logic [31:0] fl);
      int i;
      xfer(32'h0c, 1'b0, 32'h0);
      for (i = 0; i < 100 && rd !== st; i++)
         xfer(32'h0c, 1'b0, 32'h0);
      chk("status", st, rd);
      rdchk("flags", 32'h08, fl);
      xfer(32'h08, 1'b1, 32'hff);
   endtask
   // Open in a protocol, then issue a command with the peer in a given mood
   task automatic run(input logic [31:0] pr, input logic [2:0] pm, input logic [31:0] cmd,
                      input logic [31:0] st, input logic [31:0] fl);
      xfer(32'h00, 1'b1, pr);
      xfer(32'h04, 1'b1, 32'h01);
      peer_mode <= pm;
      xfer(32'h04, 1'b1, cmd);
      rdchk("command", 32'h04, 32'h0);
      expect_sf(st, fl);
   endtask
   task automatic results();
      if (n_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk("command", 32'h04, 32'h0);
      rdchk("unmapped", 32'h3c, 32'h0);
      for (int i = 0; i < 4; i++)
         run(pr_tab[i], 3'd1, 32'h01, st_tab[i], 32'h0);
      run(32'h2, 3'd1, 32'h02, 32'h22, 32'h0);
      run(32'h2, 3'd1, 32'h04, 32'h22, 32'h0);
      run(32'h1, 3'd1, 32'h02, 32'h30, 32'h0);
      chk("listen_active", 32'h1, {31'h0, listen_active});
      peer_mode <= 3'd0;
      expect_sf(32'h31, 32'h01);
      run(32'h1, 3'd1, 32'h02, 32'h30, 32'h0);
      peer_mode <= 3'd4;
      expect_sf(32'h0, 32'h08);
      run(32'h1, 3'd1, 32'h04, 32'h13, 32'h0);
      expect_sf(32'h0, 32'h08);
      xfer(32'h10, 1'b1, 32'hc0a80a05);
      xfer(32'h14, 1'b1, 32'h00001f90);
      @(posedge hclk);
      chk("dest_ip", 32'hc0a80a05, dest_ip_reg);
      chk("dest_port", 32'h1f90, {16'h0, dest_port_reg});
      run(32'h1, 3'd0, 32'h04, 32'h31, 32'h01);
      run(32'h1, 3'd2, 32'h04, 32'h00, 32'h08);
      run(32'h1, 3'd3, 32'h04, 32'h00, 32'h00);
      run(32'h1, 3'd1, 32'h08, 32'h13, 32'h0);
      results();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #2000000;
      n_errors++;
      results();
   end
endmodule
